// [hw/sotx_framer.sv]
`timescale 1ns/100ps
`include "sotx_map.svh"
// What this block does
// RL1: auto modes insert F6 and 28 framing
// RL2: parity byte in first STS-1, others 00
// RL3: section mode passes undefined bytes unchanged
// RL4: framing and parity insertion enabled separately
// RL5: section mode may insert K2 on defect
// RL6: full mode values apply to all STS-1s
// RL7: trace ID every fourth STS-1, else 00
// RL8: link number in first user byte
// RL9: pointers 62/0A first, 93/FF others, H3 00
// RL10: K2 06 on defect in first STS-1
// RL11: all other full-mode overhead bytes 00
// RL12: framing corruption inverts framing bytes
// RL13: parity forcing inverts computed parity
// RL14: defect injection forces K2 to 06
// RL15: transparent option inserts no overhead
// RL16: scramble words with 1+x^6+x^7
// RL17: control bit bypasses the scrambler
// RL18: 32-bit words become 8-bit bytes
// RL19: small elastic store between word and byte
// RL20: per-channel half-rate select
// RL21: software keeps half-rate equal per group
// RL22: full rate word clock 77.76 MHz
// RL23: row is 36 overhead then 1044 payload
// RL24: full mode overrides insertion enables
// RL25: fabric clock locked to word clock
// RL26: scrambler reseeds, framing bytes unscrambled
module sotx_framer
  import sotx_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int BYTE_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic [31:0] in_data,
  output logic in_ready,
  output logic [7:0] byte_data,
  output logic byte_valid
);
  localparam int AW = $clog2(DEPTH);
  logic [8:0] ctrl_ff;
  logic [7:0] link_ff;
  logic urun_ff;
  logic [31:0] prdata_ff;
  logic [10:0] pos_ff;
  logic [3:0] row_ff;
  logic [6:0] scr_ff;
  logic [7:0] bip_ff;
  logic [7:0] acc_ff;
  logic [31:0] mem [DEPTH];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic [31:0] sh_ff;
  logic [1:0] rem_ff;
  logic [7:0] byte_ff;
  logic bval_ff;
  logic [1:0] div_ff;
  sotx_mode_t mode;
  logic [10:0] cur_pos;
  logic [3:0] cur_row;
  logic acc;
  logic full;
  logic empty;
  logic tick;
  logic [31:0] oh_word;
  logic [31:0] seq;
  logic [6:0] nxt_scr;
  logic [31:0] wdata;
  logic [7:0] wbip;
  logic [AW:0] level;
  logic wr_acc;
  logic rd_acc;

  // full mode wins over the section mode and its enables
  always_comb begin
    if (!ctrl_ff[`SOTX_C_SOH] && !ctrl_ff[`SOTX_C_FULL]) begin
      mode = SOTX_TRANSP; // RL15
    end else if (ctrl_ff[`SOTX_C_FULL]) begin
      mode = SOTX_FULL; // RL24
    end else begin
      mode = SOTX_SOH;
    end
  end

  // one overhead byte; row and byte index inside the row's overhead
  function automatic logic [7:0] sotx_oh(
    input logic [7:0] in_b,
    input logic [3:0] row,
    input logic [7:0] bidx,
    input sotx_mode_t md,
    input logic [8:0] c,
    input logic [7:0] bip,
    input logic [7:0] link
  );
    logic [1:0] col;
    logic [7:0] sts;
    logic [7:0] v;
    col = 2'(bidx / `SOTX_STS_N);
    sts = bidx % `SOTX_STS_N;
    v = in_b;
    case (md)
      SOTX_FULL: begin
        v = 8'h00; // RL11
        if (row == 4'd0 && col == 2'd0) v = `SOTX_A1; // RL1
        if (row == 4'd0 && col == 2'd1) v = `SOTX_A2; // RL1
        if (row == 4'd0 && col == 2'd2) v = (sts[1:0] == 2'd0) ? sts + 8'h01 : 8'h00; // RL7
        if (row == 4'd1 && col == 2'd0) v = (sts == 8'd0) ? bip : 8'h00; // RL2
        if (row == 4'd1 && col == 2'd2) v = (sts == 8'd0) ? link : 8'h00; // RL8
        if (row == 4'd3 && col == 2'd0) v = (sts == 8'd0) ? `SOTX_H1_FIRST : `SOTX_H1_OTHER; // RL9
        if (row == 4'd3 && col == 2'd1) v = (sts == 8'd0) ? `SOTX_H2_FIRST : `SOTX_H2_OTHER; // RL9
        if (row == 4'd4 && col == 2'd2 && sts == 8'd0 && c[`SOTX_C_RDI]) v = `SOTX_K2_RDI; // RL10 RL14
      end
      SOTX_SOH: begin
        // bytes not named below travel untouched
        if (row == 4'd0 && col == 2'd0 && c[`SOTX_C_A1A2]) v = `SOTX_A1; // RL4
        if (row == 4'd0 && col == 2'd1 && c[`SOTX_C_A1A2]) v = `SOTX_A2; // RL4
        if (row == 4'd1 && col == 2'd0 && c[`SOTX_C_B1]) v = (sts == 8'd0) ? bip : 8'h00; // RL2
        if (row == 4'd4 && col == 2'd2 && sts == 8'd0 && c[`SOTX_C_RDI]) v = `SOTX_K2_RDI; // RL5
      end
      default: v = in_b; // RL15
    endcase
    // error injection acts on whatever leaves the framing slots, and the parity slot outside transparent mode
    if (row == 4'd0 && col != 2'd2 && c[`SOTX_C_CFRM]) v = ~v; // RL12
    if (row == 4'd1 && col == 2'd0 && sts == 8'd0 && c[`SOTX_C_CPAR] && md != SOTX_TRANSP) v = ~v; // RL13
    return v;
  endfunction

  // 32 scrambler bits, first byte on the top lane
  function automatic logic [38:0] sotx_scr(input logic [6:0] s_in);
    logic [6:0] s;
    logic [31:0] q;
    s = s_in;
    q = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      q[31 - i] = s[6];
      s = {s[5:0], s[6] ^ s[5]}; // RL16
    end
    return {q, s};
  endfunction

  // word position: a start-of-frame word forces row 0, word 0
  assign cur_pos = in_sof ? 11'd0 : pos_ff;
  assign cur_row = in_sof ? 4'd0 : row_ff;
  assign full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty = (wr_ff == rd_ff);
  assign in_ready = !full;
  assign acc = in_valid && !full;

  // overhead insertion per byte lane
  for (genvar l = 0; l < 4; l++) begin : g_lane
    always_comb begin
      if (cur_pos < `SOTX_OH_WORDS) begin
        oh_word[8*l+:8] = sotx_oh(in_data[8*l+:8], cur_row, {cur_pos[5:0], 2'(3 - l)},
          mode, ctrl_ff, bip_ff, link_ff); // RL6
      end else begin
        oh_word[8*l+:8] = in_data[8*l+:8];
      end
    end
  end

  // framing words stay in the clear; the reseed lands on the word after them
  always_comb begin
    {seq, nxt_scr} = sotx_scr(scr_ff);
    if (cur_row == 4'd0 && cur_pos < `SOTX_FRM_WORDS) begin
      wdata = oh_word; // RL26
      nxt_scr = (cur_pos == `SOTX_FRM_WORDS - 11'd1) ? `SOTX_SCR_SEED : scr_ff; // RL26
    end else if (ctrl_ff[`SOTX_C_BYP]) begin
      wdata = oh_word; // RL17
    end else begin
      wdata = oh_word ^ seq; // RL16
    end
    wbip = wdata[31:24] ^ wdata[23:16] ^ wdata[15:8] ^ wdata[7:0];
  end

  // frame counters: 36 overhead words then 1044 payload words per row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= 11'd0;
      row_ff <= 4'd0;
    end else if (acc) begin
      if (cur_pos == `SOTX_ROW_WORDS - 11'd1) begin // RL23
        pos_ff <= 11'd0;
        row_ff <= (cur_row == `SOTX_ROWS - 4'd1) ? 4'd0 : cur_row + 4'd1;
      end else begin
        pos_ff <= cur_pos + 11'd1;
        row_ff <= cur_row;
      end
    end
  end

  // scrambler state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scr_ff <= `SOTX_SCR_SEED;
    end else if (acc) begin
      scr_ff <= nxt_scr;
    end
  end

  // parity over the scrambled frame, used in the following frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 8'h00;
      bip_ff <= 8'h00;
    end else if (acc) begin
      if (cur_row == 4'd0 && cur_pos == 11'd0) begin
        bip_ff <= acc_ff; // RL2
        acc_ff <= wbip;
      end else begin
        acc_ff <= acc_ff ^ wbip;
      end
    end
  end

  // byte rate divider; half rate skips every other slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'd0;
    end else if (tick || BYTE_DIV < 1) begin
      div_ff <= 2'd0;
    end else begin
      div_ff <= div_ff + 2'd1;
    end
  end
  assign tick = ctrl_ff[`SOTX_C_HALF] ? (div_ff == 2'(2 * BYTE_DIV - 1)) : (div_ff == 2'(BYTE_DIV - 1)); // RL20

  // elastic store; width conversion stalls the source through in_ready
  assign wr_acc = acc;
  assign rd_acc = tick && rem_ff == 2'd0 && !empty; // RL22
  assign level = wr_ff - rd_ff;
  always_ff @(posedge pclk) begin
    if (wr_acc) begin
      mem[wr_ff[AW-1:0]] <= wdata; // RL19
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (wr_acc) wr_ff <= wr_ff + 1'b1;
      if (rd_acc) rd_ff <= rd_ff + 1'b1;
    end
  end

  // serial byte side, most significant byte first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ff <= 32'h0000_0000;
      rem_ff <= 2'd0;
      byte_ff <= 8'h00;
      bval_ff <= 1'b0;
    end else if (rd_acc) begin
      byte_ff <= mem[rd_ff[AW-1:0]][31:24]; // RL18
      sh_ff <= {mem[rd_ff[AW-1:0]][23:0], 8'h00};
      rem_ff <= 2'd3;
      bval_ff <= 1'b1;
    end else if (tick && rem_ff != 2'd0) begin
      byte_ff <= sh_ff[31:24]; // RL18
      sh_ff <= {sh_ff[23:0], 8'h00};
      rem_ff <= rem_ff - 2'd1;
      bval_ff <= 1'b1;
    end else begin
      bval_ff <= 1'b0;
    end
  end
  assign byte_data = byte_ff;
  assign byte_valid = bval_ff;

  // apb: zero wait, read data captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != `SOTX_CTRL_OFS && paddr != `SOTX_LINK_OFS &&
    paddr != `SOTX_STAT_OFS;
  assign prdata = prdata_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `SOTX_CTRL_RST;
      link_ff <= `SOTX_LINK_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == `SOTX_CTRL_OFS) ctrl_ff <= pwdata[8:0];
      if (paddr == `SOTX_LINK_OFS) link_ff <= pwdata[7:0];
    end
  end

  // underrun: a slot with nothing to send; set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      urun_ff <= 1'b0;
    end else if (tick && rem_ff == 2'd0 && empty) begin
      urun_ff <= 1'b1;
    end else if (psel && penable && pwrite && paddr == `SOTX_STAT_OFS && pwdata[0]) begin
      urun_ff <= 1'b0;
    end
  end

  // read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `SOTX_CTRL_OFS: prdata_ff <= {23'h0, ctrl_ff};
        `SOTX_LINK_OFS: prdata_ff <= {24'h0, link_ff};
        `SOTX_STAT_OFS: prdata_ff <= {20'h0, 4'(level), row_ff, 3'h0, urun_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // checks
  a_a1_insert: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    acc && cur_row == 4'd0 && cur_pos == 11'd0 && mode == SOTX_FULL && !ctrl_ff[`SOTX_C_CFRM]
    |-> wdata == 32'hF6F6F6F6) else $error("framing A1 not inserted");
  a_a2_corrupt: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    acc && cur_row == 4'd0 && cur_pos == 11'd12 && mode == SOTX_FULL && ctrl_ff[`SOTX_C_CFRM]
    |-> wdata == 32'hD7D7D7D7) else $error("framing A2 not inverted");
  a_b1_others: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    acc && cur_row == 4'd1 && cur_pos == 11'd5 && mode == SOTX_FULL
    |-> oh_word == 32'h0000_0000) else $error("parity byte of later STS-1 not zero");
  a_h1_first: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    acc && cur_row == 4'd3 && cur_pos == 11'd0 && mode == SOTX_FULL
    |-> oh_word == 32'h62939393) else $error("pointer H1 wrong");
  a_k2_defect: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    acc && cur_row == 4'd4 && cur_pos == 11'd24 && mode != SOTX_TRANSP && ctrl_ff[`SOTX_C_RDI]
    |-> oh_word[31:24] == 8'h06) else $error("K2 defect code missing");
  a_f1_link: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    acc && cur_row == 4'd1 && cur_pos == 11'd24 && mode == SOTX_FULL
    |-> oh_word == {link_ff, 24'h000000}) else $error("link number misplaced");
  a_transparent: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    acc && mode == SOTX_TRANSP |-> oh_word == in_data) else $error("transparent word altered");
  a_scr_reseed: assert property (@(posedge pclk) disable iff (!presetn) // RL26
    acc && cur_row == 4'd0 && cur_pos == 11'd23 |=> scr_ff == 7'h7F) else $error("scrambler not reseeded");
  a_bypass: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    acc && ctrl_ff[`SOTX_C_BYP] |-> wdata == oh_word) else $error("bypass still scrambles");
  a_byte_order: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    tick && rem_ff != 2'd0 |=> byte_valid && byte_data == $past(sh_ff[31:24]))
    else $error("byte order broken");
  a_half_rate: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    ctrl_ff[`SOTX_C_HALF] && $past(ctrl_ff[`SOTX_C_HALF]) && tick |=> !tick) else $error("half rate too fast");

  // later lanes and rows of the overhead, store bound, frame start and row length
  a_j0_ident: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    acc && cur_row == 4'd0 && cur_pos == 11'd24 && mode == SOTX_FULL
    |-> oh_word == 32'h0100_0000) else $error("trace byte wrong");
  a_h2_other: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    acc && cur_row == 4'd3 && cur_pos == 11'd13 && mode == SOTX_FULL
    |-> oh_word == 32'hFFFF_FFFF) else $error("pointer H2 of later STS-1 wrong");
  a_k2_others: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    acc && cur_row == 4'd4 && cur_pos == 11'd24 && mode == SOTX_FULL
    |-> oh_word[23:0] == 24'h00_0000) else $error("K2 of later STS-1 not zero");
  a_b1_invert: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    acc && cur_row == 4'd1 && cur_pos == 11'd0 && mode == SOTX_FULL && ctrl_ff[`SOTX_C_CPAR]
    |-> oh_word[31:24] == ~bip_ff) else $error("parity byte not inverted");
  a_soh_pass: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    acc && cur_row == 4'd2 && cur_pos < `SOTX_OH_WORDS && mode == SOTX_SOH
    |-> oh_word == in_data) else $error("section mode altered a passed byte");
  a_store_bound: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    level <= (AW+1)'(DEPTH)) else $error("store fill beyond depth");
  a_sof_restart: assert property (@(posedge pclk) disable iff (!presetn) // RL23
    acc && in_sof |=> pos_ff == 11'd1 && row_ff == 4'd0) else $error("frame start not honoured");
  a_row_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RL23
    acc && cur_pos == `SOTX_ROW_WORDS - 11'd1 |=> pos_ff == 11'd0) else $error("row length wrong");
endmodule

// [hw/sotx_map.svh]
`ifndef SOTX_MAP_SVH
`define SOTX_MAP_SVH
// apb register offsets
`define SOTX_CTRL_OFS 12'h000
`define SOTX_LINK_OFS 12'h004
`define SOTX_STAT_OFS 12'h008
// control field positions
`define SOTX_C_SOH 0
`define SOTX_C_FULL 1
`define SOTX_C_A1A2 2
`define SOTX_C_B1 3
`define SOTX_C_RDI 4
`define SOTX_C_CFRM 5
`define SOTX_C_CPAR 6
`define SOTX_C_BYP 7
`define SOTX_C_HALF 8
`define SOTX_CTRL_RST 9'h000
`define SOTX_LINK_RST 8'h00
// frame geometry in 32-bit words
`define SOTX_OH_WORDS 11'd36
`define SOTX_SPE_WORDS 11'd1044
`define SOTX_ROW_WORDS 11'd1080
`define SOTX_ROWS 4'd9
`define SOTX_STS_N 8'd48
`define SOTX_FRM_WORDS 11'd24
// fixed overhead values
`define SOTX_A1 8'hF6
`define SOTX_A2 8'h28
`define SOTX_H1_FIRST 8'h62
`define SOTX_H2_FIRST 8'h0A
`define SOTX_H1_OTHER 8'h93
`define SOTX_H2_OTHER 8'hFF
`define SOTX_K2_RDI 8'h06
`define SOTX_SCR_SEED 7'h7F
// nominal rates
`define SOTX_WORD_KHZ 77760
`define SOTX_BYTE_KHZ 311040
`define SOTX_PCLK_KHZ 25000
`endif

// [hw/sotx_pkg.sv]
package sotx_pkg;
  // overhead handling mode
  typedef enum logic [2:0] {
    SOTX_TRANSP = 3'b001,
    SOTX_SOH = 3'b010,
    SOTX_FULL = 3'b100
  } sotx_mode_t;
endpackage

// [verif/sotx_framer_bench.sv]
`timescale 1ns/100ps
// self-checking bench for the transmit overhead framer
module sotx_framer_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, in_data;
  logic in_valid, in_sof, in_ready, byte_valid, go, zero, busy, clr;
  logic [7:0] byte_data;
  logic [12:0] nwords;
  logic [3:0] gap;
  logic [7:0] got [0:17423];
  int errors, checks_done, cnt, cyc, lastv, mingap;

  sotx_framer u_sotx_framer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_sof(in_sof), .in_data(in_data), .in_ready(in_ready), .byte_data(byte_data), .byte_valid(byte_valid));
  sotx_src u_sotx_src (.pclk(pclk), .presetn(presetn), .go(go), .zero(zero), .nwords(nwords), .gap(gap),
    .in_ready(in_ready), .in_valid(in_valid), .in_sof(in_sof), .in_data(in_data), .busy(busy));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // byte capture, byte spacing and run-time ceiling
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (clr) begin
      cnt <= 0;
      mingap <= 999;
    end else if (byte_valid === 1'b1) begin
      got[cnt] <= byte_data;
      cnt <= cnt + 1;
      lastv <= cyc;
      if (cyc - lastv < mingap) mingap <= cyc - lastv;
    end
    if (cyc == 80000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input int k, input logic [7:0] e);
    checks_done++;
    if (got[k] !== e) begin
      errors++;
      $display("[ERR] %0t byte %0d exp %h got %h", $time, k, e, got[k]);
    end
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // program control, stream n words, wait for all bytes
  task automatic run(input logic [8:0] c, input logic [12:0] n, input logic z, input logic [3:0] g);
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h000, {23'h0, c}, r, e);
    clr <= 1'b1;
    nwords <= n;
    zero <= z;
    gap <= g;
    go <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    go <= 1'b0;
    @(posedge pclk);
    while (cnt < 4 * n) @(posedge pclk);
    repeat (8) @(posedge pclk);
    chk_reg(32'(cnt), 32'(4 * n));
  endtask

  // expected byte at stream index k; bit 8 marks the computed parity byte
  function automatic logic [8:0] expb(input int k, input logic full, input logic rdi, input logic inv,
    input logic ins);
    int b, r, c, s;
    b = k % 4320;
    r = k / 4320;
    c = b / 48;
    s = b % 48;
    if (b >= 144) return {1'b0, k[7:0]};
    if (r == 0 && c < 2 && ins) return {1'b0, (c == 0 ? 8'hF6 : 8'h28) ^ {8{inv}}};
    if (r == 4 && c == 2 && s == 0 && rdi) return 9'h006;
    if (!full) return {1'b0, k[7:0]};
    if (r == 1 && c == 0 && s == 0) return 9'h100;
    if (r == 0 && c == 2 && s % 4 == 0) return {1'b0, 8'(s + 1)};
    if (r == 1 && c == 2 && s == 0) return 9'h05A;
    if (r == 3 && c == 0) return s == 0 ? 9'h062 : 9'h093;
    if (r == 3 && c == 1) return s == 0 ? 9'h00A : 9'h0FF;
    return 9'h000;
  endfunction

  task automatic cmp_run(input int n, input logic full, input logic rdi, input logic inv, input logic ins);
    logic [8:0] e;
    for (int k = 0; k < n; k++) begin
      e = expb(k, full, rdi, inv, ins);
      if (!e[8]) chk_byte(k, e[7:0]);
    end
  endtask

  // reset values, link read-back, unmapped word refused
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk_reg(r, 32'h0);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk_reg(r, 32'h0);
    apb(1'b1, 12'h004, 32'h5A, r, e);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk_reg(r, 32'h5A);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk_reg({r[31:1], e}, 32'h1);
  endtask

  // transparent, bypassed, slow source
  task automatic t_transp();
    logic [31:0] r;
    logic e;
    run(9'h080, 13'h28, 1'b0, 4'h3);
    cmp_run(160, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_reg(32'(mingap), 32'h1);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk_reg(r, 32'h1);
  endtask

  // zero data: framing bytes clear, then the reseeded sequence
  task automatic t_scram();
    logic [6:0] s;
    logic [7:0] v;
    run(9'h000, 13'h28, 1'b1, 4'h0);
    s = 7'h7F;
    v = 8'h00;
    for (int k = 0; k < 160; k++) begin
      if (k >= 96) begin
        for (int i = 7; i >= 0; i--) begin
          v[i] = s[6];
          s = {s[5:0], s[6] ^ s[5]};
        end
      end
      chk_byte(k, v);
    end
  endtask

  // section mode: framing only, parity passed, defect in K2
  task automatic t_soh();
    run(9'h095, 13'h1104, 1'b0, 4'h0);
    cmp_run(17424, 1'b0, 1'b1, 1'b0, 1'b1);
  endtask

  // full mode over cleared enables, defect, corrupted framing and forced parity
  task automatic t_full();
    logic [31:0] r;
    logic e;
    run(9'h0F2, 13'h1104, 1'b0, 4'h0);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk_reg(r, 32'h0F2);
    cmp_run(17424, 1'b1, 1'b1, 1'b1, 1'b1);
  endtask

  // half rate halves the byte pace
  task automatic t_half();
    run(9'h180, 13'h8, 1'b0, 4'h0);
    cmp_run(32, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_reg(32'(mingap), 32'h2);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    go = 1'b0;
    zero = 1'b0;
    clr = 1'b0;
    nwords = 13'h1;
    gap = 4'h0;
    errors = 0;
    checks_done = 0;
    cnt = 0;
    cyc = 0;
    lastv = 0;
    mingap = 999;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_transp();
    t_scram();
    t_soh();
    t_full();
    t_half();
    summarize();
  end
endmodule

// [verif/sotx_src.sv]
`timescale 1ns/100ps
// fabric word source: payload byte equals its stream index, held until taken
module sotx_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic zero,
  input wire logic [12:0] nwords,
  input wire logic [3:0] gap,
  input wire logic in_ready,
  output logic in_valid,
  output logic in_sof,
  output logic [31:0] in_data,
  output logic busy
);
  logic [12:0] w_ff;
  logic [3:0] wait_ff;
  logic [7:0] b0;
  assign b0 = {w_ff[5:0], 2'b00};
  // idle data toggles every cycle so a stale word never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_valid <= 1'b0;
      in_sof <= 1'b0;
      in_data <= 32'h0;
      busy <= 1'b0;
      w_ff <= 13'h0;
      wait_ff <= 4'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      w_ff <= 13'h0;
      wait_ff <= 4'h0;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      in_sof <= 1'b0;
      in_data <= ~in_data;
      busy <= (w_ff != nwords - 13'h1);
      w_ff <= w_ff + 13'h1;
      wait_ff <= gap;
    end else if (!in_valid && busy && wait_ff == 4'h0) begin
      in_valid <= 1'b1;
      in_sof <= (w_ff == 13'h0);
      in_data <= zero ? 32'h0 : {b0, b0 + 8'h01, b0 + 8'h02, b0 + 8'h03};
    end else if (!in_valid) begin
      in_data <= ~in_data;
      wait_ff <= (wait_ff == 4'h0) ? 4'h0 : wait_ff - 4'h1;
    end
  end
endmodule
